// File: hdl/tmds_pkg.sv
// constants for the text message display sequencer
// assumes one 200 MHz clock and a plain register port
package tmds_pkg;
  // slot and frame geometry
  localparam int SLOTS = 16;
  localparam int RET_SLOTS = 8;
  localparam int COLS = 12;
  localparam int LINES = 4;
  localparam int CHARS = LINES * COLS;
  localparam int VALS = 8;
  localparam int VAL_LEN = 4;
  localparam int VAL_COL = (COLS - VAL_LEN) / 2;
  // rotation period, 4 s at 200 MHz
  localparam int CLK_MHZ = 200;
  localparam int ROT_TIME_MS = 4000;
  localparam int ROT_CYCLES = ROT_TIME_MS * 1000 * CLK_MHZ;
  // register offsets
  localparam logic [7:0] ADDR_RETAIN = 8'h00;
  localparam logic [7:0] ADDR_SCALE = 8'h04;
  localparam logic [7:0] ADDR_PTR = 8'h08;
  localparam logic [7:0] ADDR_CHAR = 8'h0C;
  localparam logic [7:0] ADDR_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // reset values
  localparam logic [7:0] RETAIN_RST = 8'h00;
  localparam logic [1:0] SCALE_RST = 2'h0;
  // status fields
  localparam int ST_CUR = 16;
  localparam int ST_SHOWN = 20;
  localparam int ST_EDIT = 21;
  // slot config fields
  localparam int CFG_IDX2 = 0;
  localparam int CFG_ED2 = 3;
  localparam int CFG_IDX3 = 4;
  localparam int CFG_ED3 = 7;
  // key bit positions
  localparam int K_OK = 0;
  localparam int K_ESC = 1;
  localparam int K_ALT = 2;
  localparam int K_DEL = 3;
  localparam int K_UP = 4;
  localparam int K_DN = 5;
  localparam int K_LT = 6;
  localparam int K_RT = 7;
  // scaling formats and limits
  localparam logic [1:0] FMT_UNS = 2'h0;
  localparam logic [1:0] FMT_SGN = 2'h1;
  localparam logic [1:0] FMT_DEC = 2'h2;
  localparam int ADC_MAX = 1023;
  localparam int UNS_MAX = 9999;
  localparam int SGN_MAX = 999;
  localparam int DEC_MAX = 99;
  // printable character range
  localparam logic [7:0] CH_LO = 8'h20;
  localparam logic [7:0] CH_HI = 8'h7E;
  typedef enum logic [1:0] {TMDS_NORM, TMDS_SELECT, TMDS_DIGIT} tmds_edit_e;
endpackage

// File: hdl/tmds_top.sv
// text message display sequencer: slots, rotation, alarm, entry
// assumes coils, mode and values come from same-clock logic;
// keys come from the keypad pins and are synchronised here
//
// Operation
// - sixteen text slots, coil and contact each
// - raised coil shows that slot's text
// - only in run with status view first
// - several texts rotate every 4 s
// - rotation stops on listed events
// - alarm slot wins, holds until ended
// - first eight slots may keep contact state
// - retentive slots resume on restart to run
// - frame is four lines of 12 chars
// - two centred values on lines two, three
// - edit only shown slot's constant setpoints
// - text frozen during entry, actuals refresh
// - alternate key selects, up/down steps values
// - confirm enters digit edit at top digit
// - escape with no digit leaves entry
// - analog scaled to three display formats
// - only printable ascii stored
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module tmds_top
  import tmds_pkg::*;
#(
  parameter int ROT_CNT = ROT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // control program side
  input wire logic [tmds_pkg::SLOTS-1:0] coil_i,
  input wire logic run_i,
  input wire logic power_ok_i,
  input wire logic status_view_i,
  input wire logic [tmds_pkg::VALS*16-1:0] value_i,
  input wire logic [9:0] analog_i,
  // keypad pins
  input wire logic [7:0] keys_i,
  // display side
  input wire logic [5:0] disp_addr_i,
  output logic [7:0] disp_char_o,
  output logic [tmds_pkg::SLOTS-1:0] contact_o,
  output logic shown_o,
  output logic [3:0] slot_o,
  output logic frozen_o,
  output logic [15:0] val2_o,
  output logic [15:0] val3_o,
  output logic cursor_fld_o,
  output logic [1:0] cursor_dig_o,
  output logic [15:0] scaled_o,
  // setpoint write-back
  output logic sp_wr_o,
  output logic [2:0] sp_idx_o,
  output logic [15:0] sp_val_o
);
  import tmds_pkg::*;

  logic [7:0] retain_reg;
  logic [1:0] fmt_reg;
  logic [9:0] ptr_reg;
  logic [7:0] cfg_mem [SLOTS];
  logic [7:0] char_mem [SLOTS*64];
  logic [SLOTS-1:0] contact_reg;
  logic run_d_reg;
  logic show_en_reg;
  logic [3:0] cur_reg;
  logic [31:0] tmr_reg;
  tmds_edit_e state_reg;
  logic fld_reg;
  logic [1:0] dig_reg;
  logic [15:0] edit_reg;
  logic [7:0] key_s1_reg, key_s2_reg, key_d_reg;
  logic [7:0] kp;
  logic shown, menu_open, ed2, ed3, fld_ed;
  logic [7:0] cfg;
  logic [2:0] idx2, idx3, fld_idx;
  logic [15:0] val2_reg, val3_reg, sp_val_reg, scaled_reg;
  logic [2:0] sp_idx_reg;
  logic sp_wr_reg;
  logic [7:0] disp_char_reg;
  logic [31:0] rdata_reg;
  logic signed [31:0] sc_next;

  // next active non-alarm slot above cur, wrapping
  function automatic logic [3:0] next_act(input logic [3:0] c,
                                         input logic [SLOTS-1:0] a);
    logic [3:0] r;
    logic [3:0] k;
    logic hit;
    r = c;
    hit = 1'b0;
    for (int j = 1; j < SLOTS; j++) begin
      k = 4'(c + 4'(j));
      if (!hit && k != 4'h0 && a[k]) begin
        r = k;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // one bcd digit up or down, wrapping 0..9
  function automatic logic [15:0] bcd_step(input logic [15:0] v,
                                          input logic [1:0] d,
                                          input logic up);
    logic [3:0] n;
    logic [15:0] r;
    n = v[{d, 2'b00} +: 4];
    if (up) n = (n >= 4'h9) ? 4'h0 : 4'(n + 4'h1);
    else n = (n == 4'h0) ? 4'h9 : 4'(n - 4'h1);
    r = v;
    r[{d, 2'b00} +: 4] = n;
    return r;
  endfunction

  // keypad pins: two flops, then rising-edge pulses
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      key_s1_reg <= 8'h00;
      key_s2_reg <= 8'h00;
      key_d_reg <= 8'h00;
    end else begin
      key_s1_reg <= keys_i;
      key_s2_reg <= key_s1_reg;
      key_d_reg <= key_s2_reg;
    end
  end
  assign kp = key_s2_reg & ~key_d_reg;

  // register writes; char data filtered to printables
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      retain_reg <= RETAIN_RST;
      fmt_reg <= SCALE_RST;
      ptr_reg <= 10'h000;
      for (int i = 0; i < SLOTS; i++) cfg_mem[i] <= 8'h00;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_RETAIN: retain_reg <= wdata_i[7:0];
        ADDR_SCALE: fmt_reg <= wdata_i[1:0];
        ADDR_PTR: ptr_reg <= wdata_i[9:0];
        ADDR_CFG: cfg_mem[ptr_reg[9:6]] <= wdata_i[7:0];
        ADDR_CHAR: begin
          // pointer walks 48 chars then the next slot
          if (ptr_reg[5:0] == 6'(CHARS - 1)) ptr_reg <= {4'(ptr_reg[9:6] + 4'h1), 6'h00};
          else ptr_reg <= 10'(ptr_reg + 10'h001);
        end
        default: ;
      endcase
    end
  end

  // frame store, no reset: text is content, not control
  always_ff @(posedge clk_i) begin
    if (wr_i && addr_i == ADDR_CHAR) begin
      if (wdata_i[7:0] >= CH_LO && wdata_i[7:0] <= CH_HI)
        char_mem[ptr_reg] <= wdata_i[7:0];
      else
        char_mem[ptr_reg] <= CH_LO;
    end
  end

  // display char fetch of the shown slot, line*12+col
  always_ff @(posedge clk_i) begin
    if (reset_i) disp_char_reg <= CH_LO;
    else if (disp_addr_i < 6'(CHARS)) disp_char_reg <= char_mem[{cur_reg, disp_addr_i}];
    else disp_char_reg <= CH_LO;
  end

  // register reads, data valid the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) rdata_reg <= 32'h0000_0000;
    else if (rd_i) begin
      case (addr_i)
        ADDR_RETAIN: rdata_reg <= {24'h00_0000, retain_reg};
        ADDR_SCALE: rdata_reg <= {30'h0000_0000, fmt_reg};
        ADDR_PTR: rdata_reg <= {22'h00_0000, ptr_reg};
        ADDR_CFG: rdata_reg <= {24'h00_0000, cfg_mem[ptr_reg[9:6]]};
        ADDR_STATUS: rdata_reg <= {9'h000, state_reg, shown, cur_reg, contact_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else rdata_reg <= 32'h0000_0000;
  end

  // contacts follow coils in run; stop and power loss
  // clear all but retentive slots, which hold
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      contact_reg <= '0;
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run_i && power_ok_i;
      for (int i = 0; i < SLOTS; i++) begin
        if (run_i && power_ok_i) begin
          // first run cycle keeps stored retentive state
          if (!run_d_reg && i < RET_SLOTS && retain_reg[i]) contact_reg[i] <= contact_reg[i];
          else contact_reg[i] <= coil_i[i];
        end else if (!(i < RET_SLOTS && retain_reg[i])) begin
          contact_reg[i] <= 1'b0;
        end
      end
    end
  end

  // a menu opens on confirm outside entry, or delete+alternate
  assign menu_open = (state_reg == TMDS_NORM && kp[K_OK]) ||
                     (key_s2_reg[K_DEL] && key_s2_reg[K_ALT] && (kp[K_DEL] || kp[K_ALT]));

  // presentation armed only from the status view with nothing raised
  always_ff @(posedge clk_i) begin
    if (reset_i) show_en_reg <= 1'b0;
    else if (!run_i || !power_ok_i || menu_open || !status_view_i) show_en_reg <= 1'b0;
    else if (contact_reg == '0) show_en_reg <= 1'b1;
  end
  assign shown = show_en_reg && (contact_reg != '0);

  // slot selection: alarm first, else timed ascending rotation
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur_reg <= 4'h0;
      tmr_reg <= 32'h0;
    end else if (!shown) begin
      cur_reg <= next_act(4'h0, contact_reg);
      tmr_reg <= 32'h0;
    end else if (contact_reg[0]) begin
      cur_reg <= 4'h0;
      tmr_reg <= 32'h0;
    end else if (!contact_reg[cur_reg] || cur_reg == 4'h0) begin
      cur_reg <= next_act(cur_reg, contact_reg);
      tmr_reg <= 32'h0;
    end else if (state_reg != TMDS_NORM) begin
      tmr_reg <= tmr_reg;
    end else if (tmr_reg == 32'(ROT_CNT - 1)) begin
      cur_reg <= next_act(cur_reg, contact_reg);
      tmr_reg <= 32'h0;
    end else begin
      tmr_reg <= 32'(tmr_reg + 32'h1);
    end
  end

  // value fields of the shown slot
  assign cfg = cfg_mem[cur_reg];
  assign ed2 = cfg[CFG_ED2];
  assign ed3 = cfg[CFG_ED3];
  assign idx2 = cfg[CFG_IDX2 +: 3];
  assign idx3 = cfg[CFG_IDX3 +: 3];
  assign fld_idx = fld_reg ? idx3 : idx2;
  assign fld_ed = fld_reg ? ed3 : ed2;

  // entry mode: select a constant, then edit its digits
  always_ff @(posedge clk_i) begin
    if (reset_i || !shown) begin
      state_reg <= TMDS_NORM;
      fld_reg <= 1'b0;
      dig_reg <= 2'h3;
      edit_reg <= 16'h0000;
    end else begin
      case (state_reg)
        TMDS_NORM: begin
          if (kp[K_ALT] && !key_s2_reg[K_DEL] && (ed2 || ed3)) begin
            state_reg <= TMDS_SELECT;
            fld_reg <= !ed2;
          end
        end
        TMDS_SELECT: begin
          if (kp[K_ESC]) state_reg <= TMDS_NORM;
          else if (kp[K_OK] && fld_ed) begin
            state_reg <= TMDS_DIGIT;
            dig_reg <= 2'h3;
            edit_reg <= value_i[fld_idx*16 +: 16];
          end else if ((kp[K_UP] || kp[K_DN]) && ed2 && ed3) fld_reg <= !fld_reg;
        end
        TMDS_DIGIT: begin
          if (kp[K_OK] || kp[K_ESC]) state_reg <= TMDS_SELECT;
          else if (kp[K_UP]) edit_reg <= bcd_step(edit_reg, dig_reg, 1'b1);
          else if (kp[K_DN]) edit_reg <= bcd_step(edit_reg, dig_reg, 1'b0);
          else if (kp[K_LT] && dig_reg != 2'h3) dig_reg <= 2'(dig_reg + 2'h1);
          else if (kp[K_RT] && dig_reg != 2'h0) dig_reg <= 2'(dig_reg - 2'h1);
        end
        default: state_reg <= TMDS_NORM;
      endcase
    end
  end

  // commit pulse; escape simply never writes, old value stays
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sp_wr_reg <= 1'b0;
      sp_idx_reg <= 3'h0;
      sp_val_reg <= 16'h0000;
    end else begin
      sp_wr_reg <= shown && state_reg == TMDS_DIGIT && kp[K_OK];
      if (shown && state_reg == TMDS_DIGIT && kp[K_OK]) begin
        sp_idx_reg <= fld_idx;
        sp_val_reg <= edit_reg;
      end
    end
  end

  // live values centred on lines two and three; the
  // field being edited shows the edit buffer instead
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      val2_reg <= 16'h0000;
      val3_reg <= 16'h0000;
    end else begin
      val2_reg <= (state_reg == TMDS_DIGIT && !fld_reg) ? edit_reg : value_i[idx2*16 +: 16];
      val3_reg <= (state_reg == TMDS_DIGIT && fld_reg) ? edit_reg : value_i[idx3*16 +: 16];
    end
  end

  // analog scaling; divide by full scale for exact end points
  always_comb begin
    case (fmt_reg)
      FMT_SGN: sc_next = 32'($signed({22'h0, analog_i}) * (2 * SGN_MAX) / ADC_MAX - SGN_MAX);
      FMT_DEC: sc_next = 32'($signed({22'h0, analog_i}) * (2 * DEC_MAX) / ADC_MAX - DEC_MAX);
      default: sc_next = 32'($signed({22'h0, analog_i}) * UNS_MAX / ADC_MAX);
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) scaled_reg <= 16'h0000;
    else scaled_reg <= sc_next[15:0];
  end

  assign rdata_o = rdata_reg;
  assign disp_char_o = disp_char_reg;
  assign contact_o = contact_reg;
  assign shown_o = shown;
  assign slot_o = cur_reg;
  assign frozen_o = state_reg != TMDS_NORM;
  assign val2_o = val2_reg;
  assign val3_o = val3_reg;
  assign cursor_fld_o = fld_reg;
  assign cursor_dig_o = dig_reg;
  assign scaled_o = scaled_reg;
  assign sp_wr_o = sp_wr_reg;
  assign sp_idx_o = sp_idx_reg;
  assign sp_val_o = sp_val_reg;

  // checks
  alarm_prio_a: assert property (@(posedge clk_i) disable iff (reset_i)
    shown && contact_reg[0] |=> cur_reg == 4'h0) else $error("alarm slot not shown");
  stop_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !run_i |=> !shown ##1 !shown) else $error("text shown in stop");
  rot_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    shown && state_reg != TMDS_NORM && !contact_reg[0] && contact_reg[cur_reg]
    && cur_reg != 4'h0 |=> tmr_reg == $past(tmr_reg)) else $error("rotation ran in entry");
  rot_step_a: assert property (@(posedge clk_i) disable iff (reset_i)
    shown && state_reg == TMDS_NORM && !contact_reg[0] && contact_reg[cur_reg]
    && cur_reg != 4'h0 && tmr_reg == 32'(ROT_CNT - 1)
    |=> tmr_reg == 32'h0) else $error("rotation period wrong");
  retain_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !run_i && retain_reg[3] |=> $stable(contact_reg[3])) else $error("retentive lost");
  nonret_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !power_ok_i && !retain_reg[4] |=> !contact_reg[4]) else $error("contact kept");
  follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
    run_i && power_ok_i && run_d_reg |=> contact_reg == $past(coil_i))
    else $error("contact not following coil");
  msd_a: assert property (@(posedge clk_i) disable iff (reset_i)
    shown && state_reg == TMDS_SELECT && !kp[K_ESC] && kp[K_OK] && fld_ed
    ##1 shown |-> state_reg == TMDS_DIGIT && dig_reg == 2'h3) else $error("not at top digit");
  esc_exit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_reg == TMDS_SELECT && kp[K_ESC] |=> state_reg == TMDS_NORM)
    else $error("escape did not leave entry");
  commit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    shown && state_reg == TMDS_DIGIT && kp[K_OK]
    |=> sp_wr_reg && sp_val_reg == $past(edit_reg)) else $error("commit lost");

  rot_c: cover property (@(posedge clk_i) shown && tmr_reg == 32'(ROT_CNT - 1) ##1 $changed(cur_reg));
  alarm_c: cover property (@(posedge clk_i) shown && contact_reg[0] && contact_reg[3]);
  commit_c: cover property (@(posedge clk_i) sp_wr_reg);
  abort_c: cover property (@(posedge clk_i) state_reg == TMDS_DIGIT && kp[K_ESC]);
endmodule

// File: dv/tmds_far_model.sv
// far-side model: control program coils, run mode, values and keypad
// assumes the bench calls its tasks; outputs change just after a rising edge
`timescale 1ns/1ps
module tmds_far_model
  import tmds_pkg::*;
(
  // clock
  input wire logic clk_i,
  // control program side
  output logic [tmds_pkg::SLOTS-1:0] coil_o,
  output logic run_o,
  output logic power_ok_o,
  output logic status_view_o,
  output logic [tmds_pkg::VALS*16-1:0] value_o,
  output logic [9:0] analog_o,
  // keypad pins, pulled low when released
  output logic [7:0] keys_o
);
  // power-up state: run, supply good, status view off
  initial begin
    coil_o = 16'h0000;
    run_o = 1'b1;
    power_ok_o = 1'b1;
    status_view_o = 1'b0;
    value_o = '0;
    analog_o = 10'h000;
    keys_o = 8'h00;
  end
  // coil pattern from the control program
  task automatic coils(input logic [SLOTS-1:0] c);
    @(posedge clk_i);
    coil_o <= c;
  endtask
  // run mode, supply and status view levels
  task automatic mode(input logic run, input logic pwr, input logic view);
    @(posedge clk_i);
    run_o <= run;
    power_ok_o <= pwr;
    status_view_o <= view;
  endtask
  // one live value, bcd
  task automatic set_val(input int k, input logic [15:0] v);
    @(posedge clk_i);
    value_o[k*16+:16] <= v;
  endtask
  task automatic set_analog(input logic [9:0] a);
    @(posedge clk_i);
    analog_o <= a;
  endtask
  // one press; a long hold still counts as a single press
  task automatic press(input int k, input int hold);
    @(posedge clk_i);
    keys_o[k] <= 1'b1;
    repeat (hold) @(posedge clk_i);
    keys_o[k] <= 1'b0;
    repeat (6) @(posedge clk_i);
    // settle past the edge so callers never race the design
    #1;
  endtask
endmodule

// File: dv/tmds_top_test.sv
// self-checking bench for the text message display sequencer
// assumes the far model drives coils, mode and keys; short rotation count
`timescale 1ns/1ps
module tmds_top_test;
  import tmds_pkg::*;
  localparam int ROT = 20;
  logic clk_i = 1'b0;
  logic reset_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [5:0] disp_addr_i;
  logic [31:0] rdata_o;
  logic [SLOTS-1:0] coil, contact_o;
  logic run, pwr, view, shown_o, frozen_o, cursor_fld_o, sp_wr_o;
  logic [VALS*16-1:0] value;
  logic [9:0] analog;
  logic [7:0] keys, disp_char_o;
  logic [3:0] slot_o;
  logic [15:0] val2_o, val3_o, scaled_o, sp_val_o;
  logic [1:0] cursor_dig_o;
  logic [2:0] sp_idx_o;
  logic [31:0] d;
  int miscompares = 0;
  int n_tests = 0;
  int n_wr = 0;
  int n, cyc;
  logic [15:0] sc_exp [6] = '{16'h0000, 16'h270F, 16'hFC19, 16'h03E7, 16'hFF9D, 16'h0063};

  always #2.5 clk_i = ~clk_i;

  tmds_far_model far (.clk_i(clk_i), .coil_o(coil), .run_o(run), .power_ok_o(pwr),
    .status_view_o(view), .value_o(value), .analog_o(analog), .keys_o(keys));

  tmds_top #(.ROT_CNT(ROT)) DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .coil_i(coil),
    .run_i(run), .power_ok_i(pwr), .status_view_i(view), .value_i(value),
    .analog_i(analog), .keys_i(keys), .disp_addr_i(disp_addr_i),
    .disp_char_o(disp_char_o), .contact_o(contact_o), .shown_o(shown_o),
    .slot_o(slot_o), .frozen_o(frozen_o), .val2_o(val2_o), .val3_o(val3_o),
    .cursor_fld_o(cursor_fld_o), .cursor_dig_o(cursor_dig_o), .scaled_o(scaled_o),
    .sp_wr_o(sp_wr_o), .sp_idx_o(sp_idx_o), .sp_val_o(sp_val_o));

  // count setpoint commits; a pulse stands one cycle only
  always @(posedge clk_i) begin
    if (sp_wr_o === 1'b1) n_wr++;
  end
  // hang guard, well above the planned run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk("register", exp, d);
  endtask
  task automatic dchk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    disp_addr_i <= a;
    repeat (2) @(posedge clk_i);
    #1 chk("char", {24'h0, exp}, {24'h0, disp_char_o});
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  // wait for the shown slot to move, counting cycles
  task automatic wait_slot(input logic [3:0] exp);
    logic [3:0] s;
    s = slot_o;
    n = 0;
    while (slot_o === s && n < 4 * ROT) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk("slot", {28'h0, exp}, {28'h0, slot_o});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    reset_i <= 1'b1;
    addr_i <= 8'h00;
    wdata_i <= 32'h0000_0000;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    disp_addr_i <= 6'h00;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    // reset values, refused and unmapped places
    rchk(ADDR_STATUS, 32'h0);
    rchk(ADDR_RETAIN, 32'h0);
    rchk(8'h20, 32'h0);
    // frame of slot 3; a control byte is stored as a blank
    wr(ADDR_PTR, 32'h0C0);
    wr(ADDR_CHAR, 32'h41);
    wr(ADDR_CHAR, 32'h42);
    wr(ADDR_CHAR, 32'h07);
    rchk(ADDR_PTR, 32'h0C3);
    rchk(ADDR_CHAR, 32'h0);
    wr(ADDR_PTR, 32'h0C0);
    wr(ADDR_CFG, 32'hDA);
    rchk(ADDR_CFG, 32'hDA);
    far.set_val(2, 16'h0012);
    far.set_val(5, 16'h0008);
    // no presentation without status view first
    far.coils(16'h0008);
    settle(3);
    chk("shown", 1'b0, shown_o);
    far.mode(1'b1, 1'b1, 1'b1);
    settle(3);
    chk("shown", 1'b0, shown_o);
    far.coils(16'h0000);
    settle(3);
    far.coils(16'h0008);
    settle(3);
    chk("shown", 1'b1, shown_o);
    chk("slot", 32'h3, {28'h0, slot_o});
    chk("contact", 32'h0008, {16'h0, contact_o});
    dchk(6'd0, 8'h41);
    dchk(6'd1, 8'h42);
    dchk(6'd2, 8'h20);
    dchk(6'd48, 8'h20);
    chk("value2", 32'h0012, {16'h0, val2_o});
    chk("value3", 32'h0008, {16'h0, val3_o});
    // rotation in ascending order with wrap
    far.coils(16'h0228);
    wait_slot(4'h5);
    wait_slot(4'h9);
    chk("period", 1'b1, n >= ROT - 1 && n <= ROT + 1);
    wait_slot(4'h3);
    // alarm wins and holds
    far.coils(16'h0229);
    settle(3);
    chk("alarm", 32'h0, {28'h0, slot_o});
    settle(3 * ROT);
    chk("alarm", 32'h0, {28'h0, slot_o});
    far.coils(16'h0228);
    settle(3);
    chk("alarm off", 1'b1, slot_o !== 4'h0);
    far.coils(16'h0008);
    settle(4);
    chk("slot", 32'h3, {28'h0, slot_o});
    // entry mode walk
    far.press(K_ALT, 4);
    chk("frozen", 1'b1, frozen_o);
    chk("field", 1'b0, cursor_fld_o);
    far.press(K_UP, 4);
    chk("field", 1'b1, cursor_fld_o);
    far.press(K_DN, 20);
    chk("field", 1'b0, cursor_fld_o);
    far.set_val(5, 16'h0009);
    settle(3);
    chk("actual", 32'h0009, {16'h0, val3_o});
    far.press(K_OK, 4);
    rd(ADDR_STATUS);
    chk("entry", 32'h2, {30'h0, d[22:21]});
    chk("digit", 32'h3, {30'h0, cursor_dig_o});
    far.press(K_UP, 4);
    chk("edit", 32'h1012, {16'h0, val2_o});
    far.press(K_RT, 4);
    chk("digit", 32'h2, {30'h0, cursor_dig_o});
    far.press(K_UP, 4);
    chk("edit", 32'h1112, {16'h0, val2_o});
    far.press(K_OK, 4);
    chk("commits", 32'h1, n_wr);
    chk("sp value", 32'h1112, {16'h0, sp_val_o});
    chk("sp index", 32'h2, {29'h0, sp_idx_o});
    far.press(K_OK, 4);
    far.press(K_DN, 4);
    chk("edit", 32'h9012, {16'h0, val2_o});
    far.press(K_ESC, 4);
    chk("commits", 32'h1, n_wr);
    rd(ADDR_STATUS);
    chk("entry", 32'h1, {30'h0, d[22:21]});
    far.press(K_ESC, 4);
    chk("frozen", 1'b0, frozen_o);
    // confirm outside entry opens a menu and ends presentation
    chk("shown", 1'b1, shown_o);
    far.press(K_OK, 4);
    chk("shown", 1'b0, shown_o);
    // retention over stop and power loss
    wr(ADDR_RETAIN, 32'h08);
    far.coils(16'h0018);
    far.mode(1'b0, 1'b1, 1'b1);
    settle(3);
    chk("contact", 32'h0008, {16'h0, contact_o});
    chk("shown", 1'b0, shown_o);
    far.mode(1'b1, 1'b1, 1'b1);
    settle(3);
    chk("contact", 32'h0018, {16'h0, contact_o});
    far.mode(1'b1, 1'b0, 1'b1);
    settle(3);
    chk("contact", 32'h0008, {16'h0, contact_o});
    wr(ADDR_RETAIN, 32'h00);
    far.mode(1'b0, 1'b1, 1'b1);
    settle(3);
    chk("contact", 32'h0, {16'h0, contact_o});
    // scaling end points of every format
    for (int f = 0; f < 3; f++) begin
      wr(ADDR_SCALE, f);
      far.set_analog(10'h000);
      settle(4);
      chk("scaled", {16'h0, sc_exp[2*f]}, {16'h0, scaled_o});
      far.set_analog(10'h3FF);
      settle(4);
      chk("scaled", {16'h0, sc_exp[2*f+1]}, {16'h0, scaled_o});
    end
    complete_run();
  end
endmodule
